/* verilog/dcs_pkg.sv */
/*
 * package for the cpu clock select block: register offsets, field positions,
 * reset values, divider codes and timing counts.
 * assumes a single 50 MHz system clock and an 8-bit special register port.
 */
package dcs_pkg;
    // register byte addresses on the special register port
    localparam logic [15:0] ADDR_PROC_CLK_CTRL = 16'hFFFB;
    localparam logic [15:0] ADDR_OSC_MODE_SEL = 16'hFFF0;
    // reset values
    localparam logic [7:0] RST_PROC_CLK_CTRL = 8'h04;
    localparam logic [7:0] RST_OSC_MODE_SEL = 8'h00;
    // field positions inside the processor clock control register
    localparam int BIT_MAIN_STOP = 7;
    localparam int BIT_FEEDBACK_OFF = 6;
    localparam int BIT_SRC_STATUS = 5;
    localparam int BIT_SRC_SELECT = 4;
    localparam int BIT_MUST_ZERO = 3;
    localparam int BIT_DIV_HI = 2;
    // field position inside the oscillation mode register
    localparam int BIT_BYPASS = 0;
    // highest legal divider code
    localparam logic [2:0] DIV_MAX = 3'h4;
    // the shortest instruction takes this many cpu clocks
    localparam int CPU_CLK_PER_INSTR = 2;
    // switchover from main stays on the old clock for this many shortest instructions shifted right by the divider code; from sub for one
    localparam int SWITCH_INSTR = 16;
    // clock rate of this block
    localparam int CLK_SYS_MHZ = 50;
    // two oscillator periods of stretch after a mode write, in ns at 5 MHz
    localparam int STRETCH_NS = 400;
    localparam int STRETCH_CYC = (STRETCH_NS * CLK_SYS_MHZ) / 1000;
    // switchover engine states, gray coded from run through wait to swap; the return from swap to run flips both bits
    typedef enum logic [1:0] {
        DCS_RUN = 2'b00,
        DCS_WAIT = 2'b01,
        DCS_SWAP = 2'b11
    } dcs_state_t;
endpackage

/* verilog/dcs_edge_tick.sv */
/*
 * turns a clock level sampled from another domain into a one-cycle tick on
 * each rising edge. two synchroniser flops come first.
 * assumes the sampled clock is far slower than clk_sys.
 */
`timescale 1ns/1ns
module dcs_edge_tick
(
    // system
    input wire logic clk_sys,
    input wire logic rst_b,
    // sampled clock and its tick
    input wire logic rawClk,
    output logic tick
);
    import dcs_pkg::*;

    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } dcs_tick_t;

    dcs_tick_t st; // registered state
    dcs_tick_t next_st; // next state

    // shift the level through; only the sync and last stages feed the edge compare
    always_comb
    begin
        next_st = st;
        next_st.meta = rawClk;
        next_st.sync = st.meta;
        next_st.last = st.sync;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign tick = st.sync & ~st.last;
endmodule

/* verilog/dcs_clock_select.sv */
/*
 * cpu clock select: processor clock control and oscillation mode registers,
 * prescaler, divider chain, source switchover and oscillator controls.
 * assumes both oscillator outputs arrive as levels far slower than clk_sys;
 * the cpu clock leaves as a one-cycle enable pulse per cpu clock period.
 */
// Contract
// R1 - control register resets to 04H
// R2 - software writes zero into bit 3
// R3 - bit 5 reads active clock source
// R4 - divider codes select main/1..16 or sub/2
// R5 - mode bit bypasses or uses prescaler
// R6 - mode register resets to 00H
// R7 - mode write stretches one main period; code holds off 400 ns, two periods at 5 MHz
// R8 - mode change also switches peripheral clock
// R9 - mode register written as whole byte
// R10 - stop instruction or bit 7 halts main
// R11 - stopped main pulls output pin high
// R12 - no main stop with external clock; code has no external clock input and never blocks the stop
// R13 - subsystem oscillator never stops
// R14 - bit 6 disconnects sub feedback resistor
// R15 - on sub clock, stop main via bit
// R16 - instruction takes two cpu clocks
// R17 - switch lands after old-clock instruction delay
// R18 - main stops only once on sub clock
// R19 - status bit write ignored, shows source
`timescale 1ns/1ns
module dcs_clock_select
(
    // system
    input wire logic clk_sys,
    input wire logic rst_b,
    // special register port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // oscillator samples and standby
    input wire logic main_osc_in_pin,
    input wire logic sub_osc_in_pin,
    input wire logic stopInstr,
    // oscillator controls
    output logic mainOscEnable,
    output logic main_osc_out_pin,
    output logic main_osc_out_pin_oe,
    output logic subOscEnable,
    output logic sub_feedback_resistor_off,
    // generated clock enables
    output logic cpuClkTick,
    output logic periphClkTick,
    output logic instrTick
);
    import dcs_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl; // processor clock control, bit 5 unused here
        logic [7:0] mode; // oscillation mode select
        logic srcActive; // source now clocking the cpu, 1 = subsystem
        logic [2:0] divActive; // divider code now in force
        logic [4:0] preCnt; // prescaler and divider chain
        logic subHalf; // halves the sub clock for the cpu
        logic [4:0] instrLeft; // old-clock instructions still to run
        logic cpuPhase; // counts cpu clocks within one instruction
        logic [7:0] stretch; // cycles of mode write hold-off
        logic cpuTick; // registered cpu clock enable
        logic perTick; // registered peripheral clock enable
        logic insTick; // registered instruction boundary
        logic [7:0] rdata; // registered read data
        dcs_state_t fsm; // switchover engine
    } dcs_main_t;

    dcs_main_t st;
    dcs_main_t next_st;
    logic mainTick; // rising edge of main oscillator
    logic subTick; // rising edge of sub oscillator
    logic mainStopped; // main oscillator halted

    // main stop bit only bites once the cpu runs on the subsystem clock
    assign mainStopped = stopInstr | (st.ctrl[BIT_MAIN_STOP] & st.srcActive); // R10 R18 R15 R12

    // legal codes only; a prohibited code keeps the slowest main setting
    function automatic logic [2:0] legal_div(input logic [2:0] code);
        legal_div = (code > DIV_MAX) ? DIV_MAX : code;
    endfunction

    // chain bit whose rollover gives the selected cpu tick
    function automatic logic div_hit(input logic [4:0] cnt, input logic [2:0] code, input logic pre);
        logic [5:0] mask;
        mask = (6'h01 << code) - 6'h01;
        if (!pre)
        begin
            mask = {mask[4:0], 1'b1};
        end
        div_hit = (({1'b0, cnt} & mask) == mask);
    endfunction

    dcs_edge_tick u_main
    (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .rawClk(main_osc_in_pin),
        .tick(mainTick)
    );

    dcs_edge_tick u_sub
    (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .rawClk(sub_osc_in_pin),
        .tick(subTick)
    );

    // all state update
    always_comb
    begin
        logic mainPre;
        logic mainCpu;
        logic subCpu;
        logic newTick;
        logic modeWr;
        mainPre = 1'b0;
        mainCpu = 1'b0;
        subCpu = 1'b0;
        newTick = 1'b0;
        modeWr = (regWrite && regAddr == ADDR_OSC_MODE_SEL);
        next_st = st;
        next_st.cpuTick = 1'b0;
        next_st.perTick = 1'b0;
        next_st.insTick = 1'b0;
        // register writes; status bit and bit 3 never stored
        if (regWrite && regAddr == ADDR_PROC_CLK_CTRL)
        begin
            next_st.ctrl = regWdata & 8'hD7; // R19 R2
        end
        // a mode write reloads the hold-off and swallows that cycle's main edge,
        // so a rewrite during a running hold-off cannot be lost
        if (modeWr)
        begin
            next_st.mode = {7'h00, regWdata[BIT_BYPASS]}; // R9 R5
            next_st.stretch = 8'(STRETCH_CYC); // R7
        end
        else if (st.stretch != 8'h00)
        begin
            next_st.stretch = st.stretch - 8'h01; // R7
        end
        else if (mainTick && !mainStopped)
        begin
            next_st.preCnt = st.preCnt + 5'h01;
            mainPre = st.mode[BIT_BYPASS] | st.preCnt[0]; // R5 R8
            mainCpu = div_hit(st.preCnt, st.divActive, st.mode[BIT_BYPASS]); // R4
        end
        next_st.perTick = mainPre; // R8
        // sub halver has its own bit so sub edges never disturb the main chain
        subCpu = subTick & st.subHalf;
        if (subTick)
        begin
            next_st.subHalf = ~st.subHalf; // R4
        end
        newTick = st.srcActive ? subCpu : mainCpu; // R4
        next_st.cpuTick = newTick;
        if (newTick)
        begin
            next_st.cpuPhase = ~st.cpuPhase;
            next_st.insTick = st.cpuPhase; // R16
        end
        // switchover engine: old clock keeps running for a few instructions
        unique case (st.fsm)
            DCS_RUN:
            begin
                if (next_st.ctrl[BIT_SRC_SELECT] != st.srcActive ||
                    legal_div(next_st.ctrl[BIT_DIV_HI:0]) != st.divActive)
                begin
                    next_st.fsm = DCS_WAIT;
                    next_st.instrLeft = st.srcActive ? 5'h01 :
                        5'((SWITCH_INSTR >> st.divActive)); // R17
                end
            end
            DCS_WAIT:
            begin
                if (st.insTick)
                begin
                    next_st.instrLeft = st.instrLeft - 5'h01;
                    if (st.instrLeft == 5'h01)
                    begin
                        next_st.fsm = DCS_SWAP;
                    end
                end
            end
            DCS_SWAP:
            begin
                next_st.srcActive = st.ctrl[BIT_SRC_SELECT]; // R17 R3
                next_st.divActive = legal_div(st.ctrl[BIT_DIV_HI:0]); // R4
                next_st.cpuPhase = 1'b0;
                next_st.fsm = DCS_RUN;
            end
        endcase
        // read mux, status bit from the engine
        next_st.rdata = 8'h00;
        if (regRead && regAddr == ADDR_PROC_CLK_CTRL)
        begin
            next_st.rdata = st.ctrl;
            next_st.rdata[BIT_SRC_STATUS] = st.srcActive; // R3 R19
        end
        else if (regRead && regAddr == ADDR_OSC_MODE_SEL)
        begin
            next_st.rdata = st.mode;
        end
    end

    // state register; reset loads documented defaults
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '0;
            st.ctrl <= RST_PROC_CLK_CTRL; // R1
            st.mode <= RST_OSC_MODE_SEL; // R6
            st.divActive <= DIV_MAX; // R1
            st.fsm <= DCS_RUN;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign regRdata = st.rdata;
    assign mainOscEnable = ~mainStopped; // R10
    assign main_osc_out_pin = 1'b1; // R11
    assign main_osc_out_pin_oe = mainStopped; // R11
    assign subOscEnable = 1'b1; // R13
    assign sub_feedback_resistor_off = st.ctrl[BIT_FEEDBACK_OFF]; // R14
    assign cpuClkTick = st.cpuTick;
    assign periphClkTick = st.perTick;
    assign instrTick = st.insTick;

    property p_reset_ctrl;
        @(posedge clk_sys) $rose(rst_b) |-> st.ctrl == RST_PROC_CLK_CTRL && st.mode == RST_OSC_MODE_SEL;
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("reset values wrong"); // R1
    property p_zero_bits;
        @(posedge clk_sys) disable iff (!rst_b) st.ctrl[BIT_MUST_ZERO] == 1'b0 && st.mode[7:1] == 7'h00;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("fixed bits stored"); // R2
    property p_status_read;
        @(posedge clk_sys) disable iff (!rst_b)
            regRead && regAddr == ADDR_PROC_CLK_CTRL |=> regRdata[BIT_SRC_STATUS] == $past(st.srcActive);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong"); // R19
    property p_stretch;
        @(posedge clk_sys) disable iff (!rst_b)
            regWrite && regAddr == ADDR_OSC_MODE_SEL |=> !st.perTick [*8];
    endproperty
    a_stretch: assert property (p_stretch) else $error("mode write no stretch"); // R7
    property p_main_stop;
        @(posedge clk_sys) disable iff (!rst_b)
            st.ctrl[BIT_MAIN_STOP] && !st.srcActive && !stopInstr |-> mainOscEnable;
    endproperty
    a_main_stop: assert property (p_main_stop) else $error("main stopped early"); // R18
    property p_pullup;
        @(posedge clk_sys) disable iff (!rst_b) !mainOscEnable |-> main_osc_out_pin_oe && main_osc_out_pin;
    endproperty
    a_pullup: assert property (p_pullup) else $error("pin not pulled up"); // R11
    property p_sub_run;
        @(posedge clk_sys) disable iff (!rst_b) subOscEnable;
    endproperty
    a_sub_run: assert property (p_sub_run) else $error("sub osc stopped"); // R13
    property p_frc;
        @(posedge clk_sys) disable iff (!rst_b)
            regWrite && regAddr == ADDR_PROC_CLK_CTRL |=> sub_feedback_resistor_off == $past(regWdata[6]);
    endproperty
    a_frc: assert property (p_frc) else $error("feedback bit wrong"); // R14
    property p_instr;
        @(posedge clk_sys) disable iff (!rst_b) st.insTick |-> st.cpuTick && !st.cpuPhase;
    endproperty
    a_instr: assert property (p_instr) else $error("instruction length wrong"); // R16
    property p_swap;
        @(posedge clk_sys) disable iff (!rst_b) $changed(st.srcActive) |-> $past(st.fsm) == DCS_SWAP;
    endproperty
    a_swap: assert property (p_swap) else $error("source switched directly"); // R17
    c_to_sub: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(st.srcActive));
    c_main_off: cover property (@(posedge clk_sys) disable iff (!rst_b) $fell(mainOscEnable));
    c_mode_wr: cover property (@(posedge clk_sys) disable iff (!rst_b) regWrite && regAddr == ADDR_OSC_MODE_SEL);
endmodule

/* tb/dcs_osc_model.sv */
/*
 * oscillator partner: main and subsystem crystal levels for the clock select block.
 * assumes the bench feeds the block's main oscillator enable back in here.
 */
`timescale 1ns/1ns
module dcs_osc_model
#(
    parameter int MAIN_HALF_NS = 100,
    parameter int SUB_HALF_NS = 800
)
(
    // control from the block
    input wire logic mainOscEnable,
    // oscillator levels
    output logic mainLevel,
    output logic subLevel
);
    // main crystal, not an external clock, so halting it is legal
    // a halted crystal sits low instead of freezing its last edge
    initial
    begin
        mainLevel = 1'h0;
        forever
        begin
            #(MAIN_HALF_NS);
            mainLevel = mainOscEnable ? ~mainLevel : 1'h0;
        end
    end
    // subsystem crystal has no stop input at all
    initial
    begin
        subLevel = 1'h0;
        forever #(SUB_HALF_NS) subLevel = ~subLevel;
    end
endmodule

/* tb/dual_oscillator_cpu_clock_select_test.sv */
/*
 * self-checking bench for the cpu clock select block.
 * assumes the design package and the oscillator partner model.
 */
`timescale 1ns/1ns
`define DCS_CHK(name, exp, got) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("[ERR] %s expected %0h seen %0h", name, exp, got); \
        end \
    end
module dual_oscillator_cpu_clock_select_test;
    import dcs_pkg::*;
    // oscillator half periods, shortened sub so the run stays brief
    localparam int MAIN_HALF_NS = 100;
    localparam int SUB_HALF_NS = 800;
    localparam int MAIN_CYC = 2 * MAIN_HALF_NS / 20;
    localparam int SUB_CPU_CYC = 4 * SUB_HALF_NS / 20;
    localparam int CEILING = 60000;
    logic clk_sys, rst_b, regWrite, regRead, stopInstr;
    logic [15:0] regAddr;
    logic [7:0] regWdata, regRdata, rd;
    logic mainLevel, subLevel, mainOscEnable, mainPin, mainPinOe, subOscEnable, feedbackOff;
    logic cpuClkTick, periphClkTick, instrTick;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n, m;
    dcs_clock_select dcs_clock_select_inst (.clk_sys(clk_sys), .rst_b(rst_b), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .main_osc_in_pin(mainLevel), .sub_osc_in_pin(subLevel), .stopInstr(stopInstr),
        .mainOscEnable(mainOscEnable), .main_osc_out_pin(mainPin), .main_osc_out_pin_oe(mainPinOe),
        .subOscEnable(subOscEnable), .sub_feedback_resistor_off(feedbackOff),
        .cpuClkTick(cpuClkTick), .periphClkTick(periphClkTick), .instrTick(instrTick));
    dcs_osc_model #(.MAIN_HALF_NS(MAIN_HALF_NS), .SUB_HALF_NS(SUB_HALF_NS)) dcs_osc_model_inst
        (.mainOscEnable(mainOscEnable), .mainLevel(mainLevel), .subLevel(subLevel));
    // 50 MHz system clock
    initial
    begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end
    // hang guard: a stuck wait counts as a mismatch
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == CEILING)
        begin
            errors++;
            print_verdict();
        end
    end
    task print_verdict;
        if (errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // register write: strobe held across exactly one rising edge
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        regWrite = 1'h1;
        regAddr = a;
        regWdata = d;
        @(negedge clk_sys);
        regWrite = 1'h0;
    endtask
    // register read: data is registered, so sample one cycle after the strobe
    task rdreg(input logic [15:0] a);
        @(negedge clk_sys);
        regRead = 1'h1;
        regAddr = a;
        @(negedge clk_sys);
        regRead = 1'h0;
        rd = regRdata;
    endtask
    function logic pick(input int which);
        pick = (which == 0) ? periphClkTick : (which == 1) ? cpuClkTick : instrTick;
    endfunction
    // cycles between two pulses of the chosen tick, sampled at falling edges
    task gap(input int which);
        n = 0;
        while (pick(which) !== 1'h1 && n < 20000)
        begin
            @(negedge clk_sys);
            n++;
        end
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end while (pick(which) !== 1'h1 && n < 20000);
    endtask
    task t_reset;
        rdreg(ADDR_PROC_CLK_CTRL);
        `DCS_CHK("ctrl reset", RST_PROC_CLK_CTRL, rd)
        rdreg(ADDR_OSC_MODE_SEL);
        `DCS_CHK("mode reset", RST_OSC_MODE_SEL, rd)
        rdreg(16'hFFF1);
        `DCS_CHK("unmapped read", 8'h00, rd)
        `DCS_CHK("sub enable", 1'h1, subOscEnable)
        `DCS_CHK("main enable", 1'h1, mainOscEnable)
        `DCS_CHK("pin drive", 1'h0, mainPinOe)
    endtask
    // prescaler in use, then bypassed; each mode write stretches the clock
    task t_mode;
        gap(0);
        `DCS_CHK("periph gap prescaled", 2 * MAIN_CYC, n)
        for (int i = 0; i < 2; i++)
        begin
            wr(ADDR_OSC_MODE_SEL, (i == 0) ? 8'hFF : 8'h01);
            m = 0;
            repeat (STRETCH_CYC)
            begin
                @(negedge clk_sys);
                if (periphClkTick === 1'h1)
                    m++;
            end
            `DCS_CHK("ticks in stretch", 0, m)
        end
        rdreg(ADDR_OSC_MODE_SEL);
        `DCS_CHK("mode upper bits", 8'h01, rd)
        gap(0);
        `DCS_CHK("periph gap bypass", MAIN_CYC, n)
    endtask
    // every legal main divider code
    task t_divider;
        for (int d = 0; d <= 4; d++)
        begin
            wr(ADDR_PROC_CLK_CTRL, 8'(d));
            repeat (18) gap(2);
            gap(1);
            `DCS_CHK("cpu gap", MAIN_CYC << d, n)
            m = n;
            gap(2);
            `DCS_CHK("instr gap", 2 * m, n)
        end
    endtask
    // read-only status bit refuses a write; the feedback bit reaches its output
    task t_fields;
        wr(ADDR_PROC_CLK_CTRL, 8'h63);
        rdreg(ADDR_PROC_CLK_CTRL);
        `DCS_CHK("ctrl refused bits", 8'h43, rd)
        `DCS_CHK("feedback off", 1'h1, feedbackOff)
        wr(ADDR_PROC_CLK_CTRL, 8'h00);
        `DCS_CHK("feedback on", 1'h0, feedbackOff)
    endtask
    // stop bit set on main waits until the sub switch lands
    task t_switch;
        repeat (18) gap(2);
        wr(ADDR_PROC_CLK_CTRL, 8'h80);
        `DCS_CHK("main runs on main", 1'h1, mainOscEnable)
        wr(ADDR_PROC_CLK_CTRL, 8'h90);
        rdreg(ADDR_PROC_CLK_CTRL);
        `DCS_CHK("old clock kept", 8'h90, rd)
        m = 0;
        do
        begin
            rdreg(ADDR_PROC_CLK_CTRL);
            m++;
        end while (rd[BIT_SRC_STATUS] !== 1'h1 && m < 500);
        `DCS_CHK("status sub", 8'hB0, rd)
        `DCS_CHK("main halted", 1'h0, mainOscEnable)
        `DCS_CHK("pin drive", 1'h1, mainPinOe)
        `DCS_CHK("pin level", 1'h1, mainPin)
        gap(1);
        `DCS_CHK("sub cpu gap", SUB_CPU_CYC, n)
        wr(ADDR_PROC_CLK_CTRL, 8'h00);
        m = 0;
        do
        begin
            rdreg(ADDR_PROC_CLK_CTRL);
            m++;
        end while (rd[BIT_SRC_STATUS] !== 1'h0 && m < 500);
        `DCS_CHK("status main", 8'h00, rd)
        `DCS_CHK("main restarted", 1'h1, mainOscEnable)
    endtask
    // standby instruction halts main with the stop bit clear
    task t_stop;
        @(negedge clk_sys);
        stopInstr = 1'h1;
        @(negedge clk_sys);
        `DCS_CHK("stop halts", 1'h0, mainOscEnable)
        `DCS_CHK("stop pin drive", 1'h1, mainPinOe)
        `DCS_CHK("stop pin level", 1'h1, mainPin)
        stopInstr = 1'h0;
        @(negedge clk_sys);
        `DCS_CHK("stop released", 1'h1, mainOscEnable)
        `DCS_CHK("pin released", 1'h0, mainPinOe)
    endtask
    // reset for four cycles, then the scenarios in order
    initial
    begin
        rst_b = 1'h0;
        regWrite = 1'h0;
        regRead = 1'h0;
        regAddr = 16'h0000;
        regWdata = 8'h00;
        stopInstr = 1'h0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_b = 1'h1;
        t_reset();
        t_mode();
        t_divider();
        t_fields();
        t_switch();
        t_stop();
        print_verdict();
    end
endmodule
